// File: core/ir_carrier_pkg.sv
package ir_carrier_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] MODE_OFFS      = 8'h00;
  localparam logic [7:0] CAR_HIGH_OFFS  = 8'h04;
  localparam logic [7:0] CAR_LOW_OFFS   = 8'h08;
  localparam logic [7:0] PUL_HIGH_OFFS  = 8'h0c;
  localparam logic [7:0] PUL_LOW_OFFS   = 8'h10;
  localparam logic [7:0] LATCH_OFFS     = 8'h14;
  localparam logic [7:0] BUFFER_OFFS    = 8'h18;
  localparam logic [7:0] STATUS_OFFS    = 8'h1c;
  localparam logic [7:0] IRQ_EN_OFFS    = 8'h20;
  localparam logic [7:0] IRQ_CLR_OFFS   = 8'h24;
  localparam logic [7:0] CLK_SEL_OFFS   = 8'h28;

  // Mode register fields
  localparam int MODE_PULSE_PS_LSB = 0;
  localparam int MODE_PULSE_EN_BIT = 3;
  localparam int MODE_CAR_PS_LSB   = 4;
  localparam int MODE_GEN_EN_BIT   = 6;

  // Reset values
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [5:0] COUNT_RST = 6'h00;
  localparam logic [7:0] PULSE_RST = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'h00;

  // Source tick: selected system clock divided by two
  localparam int SRC_DIV = 2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Status bit positions
  localparam int ST_PULSE_DONE = 0;
  localparam int ST_LATCH_LOAD = 1;
  localparam int ST_WIDTH      = 2;

endpackage

// File: core/ir_tick_div.sv
`timescale 1ns/1ps
// Prescaled tick: pulses once every (scale+1) input ticks
module ir_tick_div #(
  parameter int PS_W = 3
) (
  input  wire logic            i_ref_clk,
  input  wire logic            i_rst_n,
  input  wire logic            i_run,
  input  wire logic            i_tick,
  input  wire logic [PS_W-1:0] i_scale,
  output logic                 o_tick
);
  logic [PS_W-1:0] cnt_ff;

  // Counter restarts when stopped so the first phase is full length
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= '0;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_ff <= '0;
      o_tick <= 1'b0;
    end else if (i_tick) begin
      o_tick <= (cnt_ff >= i_scale);
      cnt_ff <= (cnt_ff >= i_scale) ? '0 : cnt_ff + 1'b1;
    end else begin
      o_tick <= 1'b0;
    end
  end
endmodule

// File: core/ir_remote_carrier_generator.sv
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module ir_remote_carrier_generator (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_sub_clk_tick,
  input  wire logic        i_timer8_irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             o_ir_carrier_out,
  output logic             o_irq
);
  import ir_carrier_pkg::*;

  logic [7:0]          carrier_mode_reg_ff;
  logic [5:0]          carrier_high_count_ff;
  logic [5:0]          carrier_low_count_ff;
  logic [7:0]          pulse_high_count_ff;
  logic [7:0]          pulse_low_count_ff;
  logic [7:0]          output_data_latch_ff;
  logic [7:0]          output_buffer_ff;
  logic                clk_sel_sub_ff;
  logic [ST_WIDTH-1:0] status_ff;
  logic [ST_WIDTH-1:0] irq_en_ff;
  logic                src_half_ff;
  logic                src_tick_ff;
  logic [5:0]          carrier_cnt_ff;
  logic                carrier_ph_ff;
  logic [7:0]          pulse_length_counter_ff;
  logic                pulse_ph_ff;
  logic                pulse_done_ff;
  logic                aw_got_ff;
  logic                w_got_ff;
  logic [7:0]          aw_addr_ff;
  logic [31:0]         w_data_ff;
  logic [3:0]          w_strb_ff;
  logic                car_tick;
  logic                pul_tick;
  logic                gen_en;
  logic                pul_en;
  logic                wr_fire;
  logic [ST_WIDTH-1:0] clr_bits;

  assign gen_en = carrier_mode_reg_ff[MODE_GEN_EN_BIT];
  assign pul_en = carrier_mode_reg_ff[MODE_PULSE_EN_BIT];

  // Byte-lane merge for writes into narrow registers
  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction

  // ---------------- AXI4-Lite write side ----------------
  assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;

  // Address and data taken in either order, response after both
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      aw_addr_ff    <= 8'h00;
      w_data_ff     <= 32'h0000_0000;
      w_strb_ff     <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_ff    <= s_axi_awaddr;
        aw_got_ff     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_ff    <= s_axi_wdata;
        w_strb_ff    <= s_axi_wstrb;
        w_got_ff     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        unique case (aw_addr_ff)
          MODE_OFFS, CAR_HIGH_OFFS, CAR_LOW_OFFS, PUL_HIGH_OFFS, PUL_LOW_OFFS,
          LATCH_OFFS, BUFFER_OFFS, STATUS_OFFS, IRQ_EN_OFFS, IRQ_CLR_OFFS,
          CLK_SEL_OFFS: s_axi_bresp <= RESP_OKAY;
          default:      s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Software-written configuration registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      carrier_mode_reg_ff   <= MODE_RST;
      carrier_high_count_ff <= COUNT_RST;
      carrier_low_count_ff  <= COUNT_RST;
      pulse_high_count_ff   <= PULSE_RST;
      pulse_low_count_ff    <= PULSE_RST;
      output_buffer_ff      <= LATCH_RST;
      irq_en_ff             <= '0;
      clk_sel_sub_ff        <= 1'b0;
    end else if (wr_fire) begin
      unique case (aw_addr_ff)
        MODE_OFFS:     carrier_mode_reg_ff <= merge8(carrier_mode_reg_ff, w_data_ff, w_strb_ff);
        CAR_HIGH_OFFS: begin
          if (w_strb_ff[0]) carrier_high_count_ff <= w_data_ff[5:0];
        end
        CAR_LOW_OFFS:  begin
          if (w_strb_ff[0]) carrier_low_count_ff <= w_data_ff[5:0];
        end
        PUL_HIGH_OFFS: pulse_high_count_ff <= merge8(pulse_high_count_ff, w_data_ff, w_strb_ff);
        PUL_LOW_OFFS:  pulse_low_count_ff <= merge8(pulse_low_count_ff, w_data_ff, w_strb_ff);
        BUFFER_OFFS:   output_buffer_ff <= merge8(output_buffer_ff, w_data_ff, w_strb_ff);
        IRQ_EN_OFFS:   begin
          if (w_strb_ff[0]) irq_en_ff <= w_data_ff[ST_WIDTH-1:0];
        end
        CLK_SEL_OFFS:  begin
          if (w_strb_ff[0]) clk_sel_sub_ff <= w_data_ff[0];
        end
        default: ;
      endcase
    end
  end

  // timer reload of latch
  // Timer reload wins over a same-cycle software write to the latch
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      output_data_latch_ff <= LATCH_RST;
    end else if (i_timer8_irq) begin
      output_data_latch_ff <= output_buffer_ff;
    end else if (wr_fire && aw_addr_ff == LATCH_OFFS && w_strb_ff[0]) begin
      output_data_latch_ff <= w_data_ff[7:0];
    end
  end

  // ---------------- AXI4-Lite read side ----------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      unique case (s_axi_araddr)
        MODE_OFFS:     s_axi_rdata <= {24'h000000, carrier_mode_reg_ff};
        CAR_HIGH_OFFS: s_axi_rdata <= {26'h0000000, carrier_high_count_ff};
        CAR_LOW_OFFS:  s_axi_rdata <= {26'h0000000, carrier_low_count_ff};
        PUL_HIGH_OFFS: s_axi_rdata <= {24'h000000, pulse_high_count_ff};
        PUL_LOW_OFFS:  s_axi_rdata <= {24'h000000, pulse_low_count_ff};
        LATCH_OFFS:    s_axi_rdata <= {24'h000000, output_data_latch_ff};
        BUFFER_OFFS:   s_axi_rdata <= {24'h000000, output_buffer_ff};
        STATUS_OFFS:   s_axi_rdata <= {30'h00000000, status_ff};
        IRQ_EN_OFFS:   s_axi_rdata <= {30'h00000000, irq_en_ff};
        IRQ_CLR_OFFS:  s_axi_rdata <= 32'h0000_0000;
        CLK_SEL_OFFS:  s_axi_rdata <= {31'h00000000, clk_sel_sub_ff};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- Source clock ----------------
  // halve selected clock
  // Main clock is this clock; sub clock arrives as a tick enable
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_half_ff <= 1'b0;
      src_tick_ff <= 1'b0;
    end else if (clk_sel_sub_ff ? i_sub_clk_tick : 1'b1) begin
      src_half_ff <= ~src_half_ff;
      src_tick_ff <= src_half_ff;
    end else begin
      src_tick_ff <= 1'b0;
    end
  end

  ir_tick_div #(.PS_W(2)) u_car_div (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (gen_en),
    .i_tick    (src_tick_ff),
    .i_scale   (carrier_mode_reg_ff[MODE_CAR_PS_LSB +: 2]),
    .o_tick    (car_tick)
  );

  ir_tick_div #(.PS_W(3)) u_pul_div (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (pul_en),
    .i_tick    (src_tick_ff),
    .i_scale   (carrier_mode_reg_ff[MODE_PULSE_PS_LSB +: 3]),
    .o_tick    (pul_tick)
  );

  // zero count parks the carrier low
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      carrier_cnt_ff <= 6'h00;
      carrier_ph_ff  <= 1'b0;
    end else if (!gen_en || carrier_high_count_ff == 6'h00 || carrier_low_count_ff == 6'h00) begin
      carrier_cnt_ff <= 6'h00;
      carrier_ph_ff  <= 1'b0;
    end else if (car_tick) begin
      if (carrier_cnt_ff + 6'h01 >=
          (carrier_ph_ff ? carrier_high_count_ff : carrier_low_count_ff)) begin
        carrier_cnt_ff <= 6'h00;
        carrier_ph_ff  <= ~carrier_ph_ff;
      end else begin
        carrier_cnt_ff <= carrier_cnt_ff + 6'h01;
      end
    end
  end

  // data pulse timer alternates high then low
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_length_counter_ff <= 8'h00;
      pulse_ph_ff             <= 1'b1;
      pulse_done_ff           <= 1'b0;
    end else if (!pul_en) begin
      pulse_length_counter_ff <= 8'h00;
      pulse_ph_ff             <= 1'b1;
      pulse_done_ff           <= 1'b0;
    end else if (pul_tick) begin
      if (pulse_length_counter_ff + 8'h01 >=
          (pulse_ph_ff ? pulse_high_count_ff : pulse_low_count_ff)) begin
        pulse_length_counter_ff <= 8'h00;
        pulse_ph_ff             <= ~pulse_ph_ff;
        pulse_done_ff           <= ~pulse_ph_ff;
      end else begin
        pulse_length_counter_ff <= pulse_length_counter_ff + 8'h01;
        pulse_done_ff           <= 1'b0;
      end
    end else begin
      pulse_done_ff <= 1'b0;
    end
  end

  // ---------------- Interrupts ----------------
  assign clr_bits = (wr_fire && aw_addr_ff == IRQ_CLR_OFFS && w_strb_ff[0]) ?
                    w_data_ff[ST_WIDTH-1:0] : '0;

  // sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_ff <= '0;
      o_irq     <= 1'b0;
    end else begin
      status_ff[ST_PULSE_DONE] <= pulse_done_ff |
                                  (status_ff[ST_PULSE_DONE] & ~clr_bits[ST_PULSE_DONE]);
      status_ff[ST_LATCH_LOAD] <= i_timer8_irq |
                                  (status_ff[ST_LATCH_LOAD] & ~clr_bits[ST_LATCH_LOAD]);
      o_irq <= |(status_ff & irq_en_ff);
    end
  end

  // gate carrier with latch bit zero
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ir_carrier_out <= 1'b0;
    end else begin
      o_ir_carrier_out <= output_data_latch_ff[0] & carrier_ph_ff & gen_en;
    end
  end

  // pin low when latch bit is zero
  a_pin_gated : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !$past(output_data_latch_ff[0]) |-> !o_ir_carrier_out)
    else $error("carrier pin high while latch bit zero");

  a_latch_reload : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_timer8_irq |=> output_data_latch_ff == $past(output_buffer_ff))
    else $error("latch not reloaded from buffer");

  // source tick never on consecutive cycles
  a_src_halved : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    src_tick_ff |=> !src_tick_ff)
    else $error("source tick not halved");

  // carrier step only on prescaled tick
  a_car_step : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (gen_en && !car_tick && $past(gen_en) && $stable(carrier_high_count_ff)
     && $stable(carrier_low_count_ff)) |=> $stable(carrier_cnt_ff))
    else $error("carrier counter moved without tick");

  // phase flips only at count end
  a_phase_flip : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (gen_en && $changed(carrier_ph_ff) && $past(gen_en)) |-> carrier_cnt_ff == 6'h00)
    else $error("carrier phase flipped mid count");

  a_gen_off : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !gen_en |=> !o_ir_carrier_out)
    else $error("pin driven while generator off");

  a_pulse_flag : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    pulse_done_ff |=> status_ff[ST_PULSE_DONE])
    else $error("pulse end did not set flag");

  a_irq_level : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    |(status_ff & irq_en_ff) |=> o_irq)
    else $error("interrupt not raised");
endmodule

// File: verification/ir_emitter_model.sv
`timescale 1ns/1ps
// Emitter driver on the carrier pin: times each finished high and low run
module ir_emitter_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_led_drive,
  output logic [15:0]      o_high_len,
  output logic [15:0]      o_low_len
);
  logic [15:0] run_ff;
  logic        last_ff;

  // Run lengths in clock cycles; a run only counts once it has ended
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_ff     <= 16'h0000;
      last_ff    <= 1'b0;
      o_high_len <= 16'h0000;
      o_low_len  <= 16'h0000;
    end else if (i_led_drive !== last_ff) begin
      if (last_ff) begin
        o_high_len <= run_ff;
      end else begin
        o_low_len <= run_ff;
      end
      run_ff  <= 16'h0001;
      last_ff <= i_led_drive;
    end else begin
      run_ff <= run_ff + 16'h0001;
    end
  end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ir_carrier_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_sub_clk_tick = 1'b0;
  logic        i_timer8_irq = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid, pin, irq;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rd;
  logic [15:0] high_len, low_len;
  logic [1:0]  sub_cnt = 2'b00;
  logic [3:0]  wstrb = 4'hf;
  int          miscompares = 0;
  int          tests_run = 0;
  int          highs;

  ir_remote_carrier_generator u_ir_remote_carrier_generator (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_sub_clk_tick(i_sub_clk_tick),
    .i_timer8_irq(i_timer8_irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .o_ir_carrier_out(pin), .o_irq(irq));

  ir_emitter_model u_ir_emitter_model (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_led_drive(pin),
    .o_high_len(high_len), .o_low_len(low_len));

  // 25 MHz reference clock
  always #20 i_ref_clk = ~i_ref_clk;

  // Sub clock edge every fourth reference cycle
  always @(posedge i_ref_clk) begin
    sub_cnt        <= sub_cnt + 2'b01;
    i_sub_clk_tick <= (sub_cnt == 2'b11);
  end

  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      miscompares++;
    end
  endtask

  // Address and data offered together; ready only lowers the valid it owns
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) begin
      $display("ERROR t=%0t exp=%h got=%h", $time, 1'b1, bvalid);
      miscompares++;
    end
    resp = bresp;
  endtask

  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100) begin
      $display("ERROR t=%0t exp=%h got=%h", $time, 1'b1, rvalid);
      miscompares++;
    end
    rd   = rdata;
    resp = rresp;
  endtask

  task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    check({30'h0, RESP_OKAY}, {30'h0, resp});
    check(exp, rd);
  endtask

  // Count cycles in which the pin is seen high
  task automatic count_highs(input int cyc);
    highs = 0;
    repeat (cyc) begin
      @(posedge i_ref_clk);
      if (pin !== 1'b0) highs++;
    end
  endtask

  // Run the carrier and compare the emitter's measured high and low runs
  task automatic carrier_run(input logic [7:0] mode, input int cyc, input int hi, input int lo);
    axi_write(MODE_OFFS, {24'h0, mode});
    repeat (cyc) @(posedge i_ref_clk);
    check(hi, {16'h0, high_len});
    check(lo, {16'h0, low_len});
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of under two thousand cycles
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    read_check(MODE_OFFS, 32'h0);
    read_check(LATCH_OFFS, 32'h0);
    read_check(STATUS_OFFS, 32'h0);
    // Unmapped place refused both ways, status is read-only
    axi_read(8'h40);
    check({30'h0, RESP_SLVERR}, {30'h0, resp});
    check(32'h0, rd);
    axi_write(8'h40, 32'h1);
    check({30'h0, RESP_SLVERR}, {30'h0, resp});
    axi_write(STATUS_OFFS, 32'h3);
    read_check(STATUS_OFFS, 32'h0);
    axi_write(CAR_HIGH_OFFS, 32'h3);
    axi_write(CAR_LOW_OFFS, 32'h2);
    // Latch bit zero clear: pin stays low although the carrier runs
    axi_write(MODE_OFFS, 32'h40);
    count_highs(60);
    check(0, highs);
    axi_write(LATCH_OFFS, 32'h1);
    carrier_run(8'h40, 80, 6, 4);
    carrier_run(8'h50, 120, 12, 8);
    carrier_run(8'h70, 200, 24, 16);
    axi_write(CLK_SEL_OFFS, 32'h1);
    // Lengths differ from the previous run so a stalled carrier cannot pass
    carrier_run(8'h50, 400, 48, 32);
    axi_write(CLK_SEL_OFFS, 32'h0);
    // Zero low count parks the carrier although the latch bit is set
    axi_write(CAR_LOW_OFFS, 32'h0);
    repeat (2) @(posedge i_ref_clk);
    count_highs(60);
    check(0, highs);
    axi_write(CAR_LOW_OFFS, 32'h2);
    // Generator disabled: pin held low
    axi_write(MODE_OFFS, 32'h00);
    repeat (4) @(posedge i_ref_clk);
    check(1'b0, pin);
    // Timer interrupt reloads latch from buffer
    axi_write(LATCH_OFFS, 32'h0);
    axi_write(BUFFER_OFFS, 32'h1);
    i_timer8_irq <= 1'b1;
    @(posedge i_ref_clk);
    i_timer8_irq <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    read_check(LATCH_OFFS, 32'h1);
    read_check(STATUS_OFFS, 32'h2);
    axi_write(IRQ_CLR_OFFS, 32'h3);
    read_check(IRQ_CLR_OFFS, 32'h0);
    // Byte lane zero off: the write is dropped
    wstrb <= 4'h0;
    axi_write(PUL_HIGH_OFFS, 32'h9);
    wstrb <= 4'hf;
    read_check(PUL_HIGH_OFFS, 32'h0);
    // Data pulse: (1+1)*(4+4) ticks of two cycles each, about 32 cycles
    axi_write(PUL_HIGH_OFFS, 32'h4);
    axi_write(PUL_LOW_OFFS, 32'h4);
    axi_write(MODE_OFFS, 32'h09);
    // First pulse ends about 33 cycles after enable; an unscaled timer near 17
    repeat (24) @(posedge i_ref_clk);
    read_check(STATUS_OFFS, 32'h0);
    repeat (50) @(posedge i_ref_clk);
    read_check(STATUS_OFFS, 32'h1);
    check(1'b0, irq);
    axi_write(IRQ_EN_OFFS, 32'h1);
    repeat (2) @(posedge i_ref_clk);
    check(1'b1, irq);
    // Stop pulses before clearing so the flag cannot come back
    axi_write(MODE_OFFS, 32'h00);
    axi_write(IRQ_CLR_OFFS, 32'h1);
    repeat (2) @(posedge i_ref_clk);
    check(1'b0, irq);
    read_check(STATUS_OFFS, 32'h0);
    end_of_test();
  end
endmodule
